/* File: rtl/icr_pkg.sv */
// Constants shared by the serial controller register block
package icr_pkg;
    // ------------------------------------------------------------
    // Special function register ports
    // ------------------------------------------------------------
    localparam logic [7:0] SFR_INDEX_ADDR = 8'h96;
    localparam logic [7:0] SFR_DATA_ADDR = 8'h97;
    localparam logic [7:0] ABORT_INDEX = 8'hff;
    // ------------------------------------------------------------
    // Internal register indices
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_PRESCALE = 8'h00;
    localparam logic [7:0] IDX_TX = 8'h02;
    localparam logic [7:0] IDX_RX = 8'h03;
    localparam logic [7:0] IDX_CTRL = 8'h04;
    localparam logic [7:0] IDX_CMD = 8'h05;
    localparam logic [7:0] IDX_MSTAT = 8'h06;
    localparam logic [7:0] IDX_RSVD = 8'h07;
    localparam logic [7:0] IDX_SADDR = 8'h08;
    localparam logic [7:0] IDX_SSTAT = 8'h0a;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] PRESCALE_RST = 16'hffff;
    localparam logic [7:0] TX_RST = 8'h00;
    localparam logic [7:0] RX_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] SADDR_RST = 8'h00;
    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int CTRL_MIRQ_EN = 0;
    localparam int CTRL_EN = 1;
    localparam int CTRL_SPEED = 2;
    localparam int CTRL_TEN_BIT = 3;
    localparam int CTRL_RELOAD = 4;
    localparam int CTRL_SIRQ_EN = 6;
    localparam int CTRL_ROLE = 7;
    localparam logic [7:0] CTRL_WMASK = 8'hdf;
    localparam int TX_DIR_BIT = 0;
    // ------------------------------------------------------------
    // Master status fields
    // ------------------------------------------------------------
    localparam int MST_TIP = 1;
    localparam int MST_RELOADING = 3;
    localparam int MST_BUSY = 6;
    localparam int MST_ACK = 7;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam logic [2:0] SCL_PHASES = 3'h5;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [7:0] RELOAD_CYCLES = 8'h40;
    localparam int FIFO_DEPTH = 16;
endpackage

/* File: rtl/icr_ctrl.sv */
// Serial controller register block, FIFO and byte engine
// Notes on behaviour
// - SCL rate is system clock over five times prescale plus one.
// - Prescale is 16 bits, low byte then high byte, resets to all ones.
// - Transmit bit 0 is direction on address bytes, one means read.
// - Transmit register holds next byte sent; it is only sent in master role.
// - Receive register is read-only, last byte captured, resets to zero.
// - Control bit 0 gates master interrupts, only in master role.
// - Control bit 1 enables the byte engine and slave interrupts; speed, address width and reload ignore it.
// - Control bit 2 picks slave speed, one standard; ignored as master.
// - Control bit 3 picks ten-bit slave addressing; ignored as master.
// - Writing one to control bit 4 starts reload; hardware clears it.
// - Control bit 6 gates slave interrupts, only in slave role.
// - Control bit 7 selects role, one master, zero slave.
// - Index space places each register at its fixed index.
// - Reads go through index then data port, low byte first.
// - Writing all ones to index aborts a partial sequence.

module icr_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [W-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } icr_fifo_st_t;

    icr_fifo_st_t q;
    icr_fifo_st_t d;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
        if (p == AW'(D - 1)) begin
            return '0;
        end
        return p + AW'(1);
    endfunction

    assign in_ready = q.cnt != (AW + 1)'(D);
    assign out_valid = q.cnt != '0;
    assign out_data = q.mem[q.rp];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        d = q;
        if (push) begin
            d.mem[q.wp] = in_data;
            d.wp = next_ptr(q.wp);
        end
        if (pop) begin
            d.rp = next_ptr(q.rp);
        end
        d.cnt = q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
        // Abort drops every queued byte
        if (flush) begin
            d.wp = '0;
            d.rp = '0;
            d.cnt = '0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

module icr_ctrl #(
    parameter logic [7:0] RELOAD_LEN = icr_pkg::RELOAD_CYCLES,
    parameter int DEPTH = icr_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_wr_ready,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    input wire logic slave_event,
    output logic master_irq,
    output logic slave_irq,
    output logic slave_std_speed,
    output logic slave_ten_bit,
    output logic reload_busy
);
    typedef enum logic {ICR_IDLE, ICR_COMMIT} icr_cstate_t;

    typedef struct packed {
        icr_cstate_t cst;
        logic [7:0] index;
        logic rd_hi;
        logic wr_hi;
        logic [7:0] rdata;
        logic [15:0] prescale;
        logic [7:0] tx;
        logic [7:0] rx;
        logic [7:0] ctrl;
        logic [7:0] saddr;
        logic [7:0] reload_cnt;
        logic busy;
        logic ack;
        logic [15:0] div;
        logic [2:0] phase;
        logic [3:0] bitn;
        logic [7:0] shift;
        logic scl_rel;
        logic sda_rel;
        logic scl_s1;
        logic scl_s2;
        logic sda_s1;
        logic sda_s2;
        logic mirq;
        logic sirq;
    } icr_st_t;

    icr_st_t q;
    icr_st_t d;
    logic idx_wr;
    logic data_wr;
    logic abort;
    logic f_valid;
    logic f_ready;
    logic [7:0] f_data;
    logic en;
    logic master;

    // ------------------------------------------------------------
    // Register read view
    // ------------------------------------------------------------
    function automatic logic [7:0] read_byte(input icr_st_t s,
                                             input logic hi);
        logic [7:0] st;
        st = '0;
        st[icr_pkg::MST_TIP] = s.busy;
        st[icr_pkg::MST_RELOADING] = s.ctrl[icr_pkg::CTRL_RELOAD];
        st[icr_pkg::MST_BUSY] = s.busy;
        st[icr_pkg::MST_ACK] = s.ack;
        if (hi) begin
            // Only the prescaler is two bytes wide
            return (s.index == icr_pkg::IDX_PRESCALE) ?
                s.prescale[15:8] : 8'h00;
        end
        case (s.index)
            icr_pkg::IDX_PRESCALE: return s.prescale[7:0];
            icr_pkg::IDX_TX: return s.tx;
            icr_pkg::IDX_RX: return s.rx;
            icr_pkg::IDX_CTRL: return s.ctrl;
            icr_pkg::IDX_MSTAT: return st;
            icr_pkg::IDX_SADDR: return s.saddr;
            default: return 8'h00;
        endcase
    endfunction

    assign idx_wr = sfr_wr && sfr_addr == icr_pkg::SFR_INDEX_ADDR;
    assign data_wr = sfr_wr && sfr_addr == icr_pkg::SFR_DATA_ADDR;
    assign abort = idx_wr && sfr_wdata == icr_pkg::ABORT_INDEX;
    assign f_ready = q.cst == ICR_COMMIT;
    assign en = q.ctrl[icr_pkg::CTRL_EN];
    // role bit picks master or slave
    assign master = q.ctrl[icr_pkg::CTRL_ROLE];

    // Data bytes wait here until the index write commits them
    icr_fifo #(
        .W(8),
        .D(DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .nrst(nrst),
        .flush(abort),
        .in_valid(data_wr),
        .in_data(sfr_wdata),
        .in_ready(sfr_wr_ready),
        .out_valid(f_valid),
        .out_data(f_data),
        .out_ready(f_ready)
    );

    localparam logic [2:0] SCL_LAST = icr_pkg::SCL_PHASES - 3'h1;
    always_comb begin
        d = q;
        d.mirq = 1'b0;
        d.sirq = 1'b0;
        // Pins pass two flops before any logic looks at them
        d.scl_s1 = scl_i;
        d.scl_s2 = q.scl_s1;
        d.sda_s1 = sda_i;
        d.sda_s2 = q.sda_s1;

        // --------------------------------------------------------
        // Indirect access sequencing
        // --------------------------------------------------------
        // data port read, low byte first
        if (sfr_rd && sfr_addr == icr_pkg::SFR_DATA_ADDR) begin
            d.rdata = read_byte(q, q.rd_hi);
            d.rd_hi = 1'b1;
        end else if (sfr_rd) begin
            d.rdata = 8'h00;
        end
        // abort drops queue and byte position
        if (abort) begin
            d.cst = ICR_IDLE;
            d.index = icr_pkg::ABORT_INDEX;
            d.rd_hi = 1'b0;
        end else if (idx_wr && q.cst == ICR_IDLE) begin
            d.index = sfr_wdata;
            d.rd_hi = 1'b0;
            d.wr_hi = 1'b0;
            // queued bytes are committed by the index write
            if (f_valid) begin
                d.cst = ICR_COMMIT;
            end
        end

        // --------------------------------------------------------
        // Boot reload timer
        // --------------------------------------------------------
        // hardware clears the reload bit when done
        if (q.reload_cnt != 8'h00) begin
            d.reload_cnt = q.reload_cnt - 8'h01;
            if (q.reload_cnt == 8'h01) begin
                d.ctrl[icr_pkg::CTRL_RELOAD] = 1'b0;
            end
        end

        // --------------------------------------------------------
        // Byte engine
        // --------------------------------------------------------
        if (q.busy) begin
            // Stretch: end of phase 3 waits out the sync lag on SCL
            if (q.phase == 3'h3 && q.div == q.prescale && !q.scl_s2) begin
                d.div = q.div;
            end else if (q.div == q.prescale) begin
                d.div = 16'h0000;
                // five phases of prescale plus one cycles each
                d.phase = (q.phase == SCL_LAST) ? 3'h0 :
                    q.phase + 3'h1;
                if (q.phase == 3'h3) begin
                    d.shift = {q.shift[6:0], q.sda_s2};
                    if (q.bitn == icr_pkg::ACK_BIT) begin
                        d.ack = !q.sda_s2;
                        d.shift = q.shift;
                    end
                end
                if (q.phase == SCL_LAST) begin
                    if (q.bitn == icr_pkg::ACK_BIT) begin
                        d.busy = 1'b0;
                        d.rx = q.shift;
                        // master events only in master role
                        d.mirq = q.ctrl[icr_pkg::CTRL_MIRQ_EN] & master;
                    end else begin
                        d.bitn = q.bitn + 4'h1;
                    end
                end
            end else begin
                d.div = q.div + 16'h0001;
            end
            d.scl_rel = d.busy ? (d.phase >= 3'h2) : 1'b1;
            if (!d.busy || d.bitn == icr_pkg::ACK_BIT) begin
                d.sda_rel = 1'b1;
            end else if (d.phase == 3'h0) begin
                d.sda_rel = d.shift[7];
            end
        end

        // slave events only in slave role
        d.sirq = slave_event & en & !master &
            q.ctrl[icr_pkg::CTRL_SIRQ_EN];

        // --------------------------------------------------------
        // Commit of queued bytes
        // --------------------------------------------------------
        if (q.cst == ICR_COMMIT) begin
            if (!f_valid) begin
                d.cst = ICR_IDLE;
            end else begin
                d.wr_hi = 1'b1;
                case (q.index)
                    icr_pkg::IDX_PRESCALE: begin
                        // low byte first, then high byte
                        if (q.wr_hi) begin
                            d.prescale[15:8] = f_data;
                        end else begin
                            d.prescale[7:0] = f_data;
                        end
                    end
                    icr_pkg::IDX_TX: begin
                        if (!q.wr_hi) begin
                            d.tx = f_data;
                        end
                    end
                    icr_pkg::IDX_CTRL: begin
                        if (!q.wr_hi) begin
                            d.ctrl = f_data & icr_pkg::CTRL_WMASK;
                            // a written one wins over the clear
                            if (f_data[icr_pkg::CTRL_RELOAD]) begin
                                d.reload_cnt = RELOAD_LEN;
                            end else begin
                                d.ctrl[icr_pkg::CTRL_RELOAD] =
                                    q.ctrl[icr_pkg::CTRL_RELOAD] &&
                                    d.reload_cnt != 8'h00;
                            end
                        end
                    end
                    icr_pkg::IDX_SADDR: begin
                        if (!q.wr_hi) begin
                            d.saddr = f_data;
                        end
                    end
                    default: begin
                    end
                endcase
                // address byte goes out with its direction bit
                if (q.index == icr_pkg::IDX_TX && !q.wr_hi &&
                    en && master && !q.busy) begin
                    d.busy = 1'b1;
                    d.div = 16'h0000;
                    d.phase = 3'h0;
                    d.bitn = 4'h0;
                    d.shift = f_data;
                    d.scl_rel = 1'b0;
                    d.sda_rel = f_data[7];
                end
            end
        end

        // disabled controller releases lines and idles
        if (!d.ctrl[icr_pkg::CTRL_EN] || !d.ctrl[icr_pkg::CTRL_ROLE]) begin
            d.busy = 1'b0;
            d.div = 16'h0000;
            d.phase = 3'h0;
            d.bitn = 4'h0;
            d.scl_rel = 1'b1;
            d.sda_rel = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.cst <= ICR_IDLE;
            q.index <= icr_pkg::IDX_PRESCALE;
            q.prescale <= icr_pkg::PRESCALE_RST;
            q.tx <= icr_pkg::TX_RST;
            q.rx <= icr_pkg::RX_RST;
            q.ctrl <= icr_pkg::CTRL_RST;
            q.saddr <= icr_pkg::SADDR_RST;
            q.scl_rel <= 1'b1;
            q.sda_rel <= 1'b1;
            q.scl_s1 <= 1'b1;
            q.scl_s2 <= 1'b1;
            q.sda_s1 <= 1'b1;
            q.sda_s2 <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Open drain: value is always low, enable low means pulling
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_n = q.scl_rel;
    assign sda_oe_n = q.sda_rel;
    assign sfr_rdata = q.rdata;
    assign master_irq = q.mirq;
    assign slave_irq = q.sirq;
    // speed select only seen in slave role
    assign slave_std_speed = q.ctrl[icr_pkg::CTRL_SPEED] & ~master;
    // address width only seen in slave role
    assign slave_ten_bit = q.ctrl[icr_pkg::CTRL_TEN_BIT] & ~master;
    assign reload_busy = q.ctrl[icr_pkg::CTRL_RELOAD];
endmodule

/* File: test/icr_ctrl_checker.sv */
// Port assertions for the serial controller register block
module icr_ctrl_checker #(
    parameter logic [7:0] RELOAD_LEN = 8'h40,
    parameter int DEPTH = 16
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_wr_ready,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe_n,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    input wire logic slave_event,
    input wire logic master_irq,
    input wire logic slave_irq,
    input wire logic slave_std_speed,
    input wire logic slave_ten_bit,
    input wire logic reload_busy
);
    timeunit 1ns;
    timeprecision 1ns;
    // Reload must end well before this bound
    localparam int RL_MAX = 300;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);
    property p_idx_rd;
        sfr_rd && sfr_addr == 8'h96 |=> sfr_rdata == 8'h00;
    endproperty
    a_idx_rd: assert property (p_idx_rd)
        else $error("index port read not zero");
    property p_open_drain;
        scl_o == 1'b0 && sda_o == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("line driven high");
    property p_mirq_pulse;
        master_irq |=> !master_irq;
    endproperty
    a_mirq_pulse: assert property (p_mirq_pulse)
        else $error("master interrupt longer than one cycle");
    property p_mirq_end;
        master_irq |-> scl_oe_n && sda_oe_n;
    endproperty
    a_mirq_end: assert property (p_mirq_end)
        else $error("master interrupt before lines released");
    property p_role_excl;
        slave_std_speed || slave_ten_bit || slave_irq |-> !master_irq;
    endproperty
    a_role_excl: assert property (p_role_excl)
        else $error("slave and master outputs together");
    property p_sirq_cause;
        slave_irq |-> $past(slave_event);
    endproperty
    a_sirq_cause: assert property (p_sirq_cause)
        else $error("slave interrupt without event");
    property p_ready_drop;
        $fell(sfr_wr_ready) |-> $past(sfr_wr) && $past(sfr_addr) == 8'h97;
    endproperty
    a_ready_drop: assert property (p_ready_drop)
        else $error("write ready fell without data write");
    property p_reload_end;
        $rose(reload_busy) |-> ##[1:RL_MAX] !reload_busy;
    endproperty
    a_reload_end: assert property (p_reload_end)
        else $error("reload never cleared");
    property p_sda_when_low;
        $fell(sda_oe_n) |-> !scl_oe_n;
    endproperty
    a_sda_when_low: assert property (p_sda_when_low)
        else $error("data pulled while clock high");
    property p_scl_low_min;
        $fell(scl_oe_n) |=> !scl_oe_n;
    endproperty
    a_scl_low_min: assert property (p_scl_low_min)
        else $error("clock low phase too short");
endmodule

/* File: test/icr_bus_model.sv */
// Far-side bus device: acks bytes, returns a pattern, may stretch
module icr_bus_model #(
    parameter int STRETCH = 12,
    parameter int HOLD = 12
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic scl,
    input wire logic sda,
    input wire logic [7:0] pattern,
    input wire logic nack,
    input wire logic slow,
    output logic scl_pull,
    output logic sda_pull,
    output logic [7:0] got,
    output logic [7:0] frames
);
    timeunit 1ns;
    timeprecision 1ns;
    logic scl_q;
    int cnt, cur, st, hd;
    assign scl_pull = st > 0;
    always @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            scl_q <= 1'b1;
            cnt <= 0;
            cur <= 0;
            st <= 0;
            hd <= 0;
            sda_pull <= 1'b0;
            got <= 8'h00;
            frames <= 8'h00;
        end else begin
            scl_q <= scl;
            if (st > 0)
                st <= st - 1;
            if (hd > 0)
                hd <= hd - 1;
            // Let go once the ack hold ends, so the line floats high
            if (hd == 1) begin
                sda_pull <= 1'b0;
                frames <= frames + 8'h01;
            end
            if (scl_q && !scl) begin
                cur <= cnt;
                cnt <= (cnt == 8) ? 0 : cnt + 1;
                sda_pull <= (cnt == 8) ? !nack : !pattern[7 - cnt];
                st <= slow ? STRETCH : 0;
            end
            if (!scl_q && scl) begin
                if (cur < 8)
                    got <= {got[6:0], sda};
                else
                    hd <= HOLD;
            end
        end
    end
endmodule

/* File: test/icr_ctrl_bench.sv */
// Self-checking bench for the serial controller register block
module icr_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [7:0] RELOAD_LEN = 8'h04;
    localparam int DEPTH = 16;
    localparam logic [7:0] IX = icr_pkg::SFR_INDEX_ADDR;
    localparam logic [7:0] DX = icr_pkg::SFR_DATA_ADDR;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic slave_event = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata, got, frames, t, f0;
    logic sfr_wr_ready, scl_o, scl_oe_n, sda_o, sda_oe_n, scl_pull;
    logic master_irq, slave_irq, slave_std_speed, slave_ten_bit;
    logic reload_busy, sda_pull;
    logic nack = 1'b0, slow = 1'b0, meas = 1'b0;
    logic rd_d = 1'b0, rl_d = 1'b0, oe_d = 1'b1;
    logic [7:0] pattern = 8'hff;
    logic [7:0] cv [4] = '{8'h0c, 8'h8c, 8'h04, 8'h08};
    logic [7:0] sv [4] = '{8'h42, 8'h02, 8'hc2, 8'h40};
    logic [7:0] exp_q [$];
    int n_fail = 0, checks_done = 0, seed = 41, per = 10, gap = 999;
    int n_mi = 0, n_si = 0, n_rl = 0, n_pull = 0, k;
    // Both lines have pull-ups: high unless someone pulls low
    wire scl_w = (scl_oe_n | scl_o) & ~scl_pull;
    wire sda_w = (sda_oe_n | sda_o) & ~sda_pull;
    always #25 core_clk = ~core_clk;
    icr_ctrl #(.RELOAD_LEN(RELOAD_LEN), .DEPTH(DEPTH)) u_icr_ctrl (
        .core_clk(core_clk), .nrst(nrst), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .sfr_wr_ready(sfr_wr_ready),
        .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .slave_event(slave_event), .master_irq(master_irq),
        .slave_irq(slave_irq), .slave_std_speed(slave_std_speed),
        .slave_ten_bit(slave_ten_bit), .reload_busy(reload_busy));
    icr_bus_model u_icr_bus_model (.core_clk(core_clk), .nrst(nrst),
        .scl(scl_w), .sda(sda_w), .pattern(pattern), .nack(nack),
        .slow(slow), .scl_pull(scl_pull), .sda_pull(sda_pull),
        .got(got), .frames(frames));
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                seen, want);
        end
    endtask
    task automatic close_out;
        if (n_fail == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge core_clk);
        sfr_wr <= w;
        sfr_rd <= ~w;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge core_clk);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b0;
    endtask
    // data bytes low first, then the index write commits
    task automatic wreg(input logic [7:0] x, input logic [15:0] v,
                        input int n);
        for (int i = 0; i < n; i++)
            acc(1'b1, DX, v[8*i +: 8]);
        acc(1'b1, IX, x);
        repeat (4) @(posedge core_clk);
    endtask
    task automatic rreg(input logic [7:0] x, input logic [15:0] v,
                        input int n);
        acc(1'b1, IX, x);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(v[8*i +: 8]);
            acc(1'b0, DX, 8'h00);
        end
    endtask
    task automatic xfer(input logic [7:0] om, input logic [7:0] m);
        int r;
        r = $random(seed);
        t = 8'(r) | om;
        @(posedge core_clk);
        pattern <= 8'(r >> 8);
        f0 = frames;
        wreg(8'h02, {8'h00, t}, 1);
        k = 0;
        while (frames === f0 && k < 3000) begin
            @(posedge core_clk);
            k++;
        end
        if (k >= 3000) begin
            n_fail++;
            close_out();
        end
        repeat (4) @(posedge core_clk);
        check(got, t & pattern);
        rreg(8'h03, {8'h00, t & pattern}, 1);
        rreg(8'h06, {8'h00, m}, 1);
    endtask
    // Result watcher and event counters
    always @(posedge core_clk) begin
        rd_d <= sfr_rd;
        if (rd_d)
            check(sfr_rdata, exp_q.pop_front());
        if (master_irq === 1'b1)
            n_mi <= n_mi + 1;
        if (slave_irq === 1'b1)
            n_si <= n_si + 1;
        if (reload_busy === 1'b1 && !rl_d)
            n_rl <= n_rl + 1;
        rl_d <= reload_busy;
        if (scl_oe_n !== 1'b1 || sda_oe_n !== 1'b1)
            n_pull <= n_pull + 1;
        gap <= (frames !== f0) ? 999 : gap + 1;
        oe_d <= scl_oe_n;
        if (oe_d && !scl_oe_n) begin
            gap <= 1;
            if (meas && gap < 40)
                check(8'(gap), 8'(per));
        end
    end
    initial begin
        repeat (6) @(posedge core_clk);
        nrst <= 1'b1;
        rreg(8'h00, 16'hffff, 2);
        rreg(8'h02, 16'h0000, 1);
        rreg(8'h03, 16'h0000, 1);
        rreg(8'h04, 16'h0000, 1);
        rreg(8'h07, 16'h0000, 1);
        exp_q.push_back(8'h00);
        acc(1'b0, 8'h90, 8'h00);
        exp_q.push_back(8'h00);
        acc(1'b0, IX, 8'h00);
        wreg(8'h00, 16'h1234, 2);
        rreg(8'h00, 16'h1234, 2);
        wreg(8'h03, 16'h005a, 1);
        rreg(8'h03, 16'h0000, 1);
        k = $random(seed);
        wreg(8'h08, 16'(k & 8'hff), 1);
        rreg(8'h08, 16'(k & 8'hff), 1);
        // Fill the buffer until it refuses, then flush it
        for (int i = 0; i <= DEPTH; i++)
            acc(1'b1, DX, 8'(i));
        check({7'h00, sfr_wr_ready}, 8'h00);
        acc(1'b1, IX, icr_pkg::ABORT_INDEX);
        @(posedge core_clk);
        check({7'h00, sfr_wr_ready}, 8'h01);
        acc(1'b1, DX, 8'h11);
        acc(1'b1, DX, 8'h22);
        wreg(8'h02, 16'h0033, 1);
        rreg(8'h02, 16'h0011, 1);
        acc(1'b1, DX, 8'h77);
        rreg(icr_pkg::ABORT_INDEX, 16'h0000, 1);
        wreg(8'h02, 16'h0000, 0);
        rreg(8'h02, 16'h0011, 1);
        foreach (cv[i]) begin
            wreg(8'h04, {8'h00, cv[i]}, 1);
            check({slave_std_speed, slave_ten_bit},
                {cv[i][2] & ~cv[i][7], cv[i][3] & ~cv[i][7]});
        end
        rreg(8'h04, 16'h0008, 1);
        wreg(8'h04, 16'h0010, 1);
        repeat (8) @(posedge core_clk);
        check(8'(n_rl), 8'h01);
        rreg(8'h04, 16'h0000, 1);
        foreach (sv[i]) begin
            k = n_si;
            wreg(8'h04, {8'h00, sv[i]}, 1);
            slave_event <= 1'b1;
            @(posedge core_clk);
            slave_event <= 1'b0;
            repeat (3) @(posedge core_clk);
            check(8'(n_si - k), 8'(sv[i][1] & sv[i][6] & ~sv[i][7]));
        end
        wreg(8'h00, 16'h0001, 2);
        wreg(8'h04, 16'h0083, 1);
        meas = 1'b1;
        xfer(8'h01, 8'h80);
        repeat (3)
            xfer(8'h00, 8'h80);
        wreg(8'h00, 16'h0002, 2);
        per = 15;
        xfer(8'h00, 8'h80);
        check(8'(n_mi), 8'h05);
        meas = 1'b0;
        slow = 1'b1;
        nack = 1'b1;
        wreg(8'h04, 16'h0082, 1);
        xfer(8'h00, 8'h00);
        check(8'(n_mi), 8'h05);
        foreach (sv[i]) begin
            wreg(8'h04, {8'h00, sv[i] ^ 8'h80}, 1);
            k = n_pull;
            wreg(8'h02, 16'h0000, 1);
            repeat (60) @(posedge core_clk);
            check(8'(n_pull != k), 8'(sv[i][1] & ~sv[i][7]));
        end
        close_out();
    end
endmodule
bind icr_ctrl icr_ctrl_checker #(.RELOAD_LEN(RELOAD_LEN), .DEPTH(DEPTH))
    u_icr_ctrl_checker (.core_clk(core_clk), .nrst(nrst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .sfr_wr_ready(sfr_wr_ready), .scl_i(scl_i), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .slave_event(slave_event),
    .master_irq(master_irq), .slave_irq(slave_irq),
    .slave_std_speed(slave_std_speed), .slave_ten_bit(slave_ten_bit),
    .reload_busy(reload_busy));
